// file: hw/hdio_debounce.sv
/*
  two-stage debounce filter for a vector of input lines.
  assumes tick is a one-cycle enable at the sampling rate, same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module hdio_debounce #(
  parameter int N = 17
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_tick,
  input wire logic [N-1:0] i_din,
  output logic [N-1:0] o_filt
);
  logic [N-1:0] st0_r, st0_nxt;
  logic [N-1:0] st1_r, st1_nxt;
  logic [N-1:0] filt_r, filt_nxt;

  // shift on each tick; the filtered level moves only where both stages agree
  always_comb begin
    st0_nxt = st0_r;
    st1_nxt = st1_r;
    filt_nxt = filt_r;
    if (i_tick) begin
      st0_nxt = i_din;
      st1_nxt = st0_r;
      filt_nxt = (st0_r & st1_r) | (filt_r & (st0_r | st1_r));
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st0_r <= '0;
      st1_r <= '0;
      filt_r <= '0;
    end else begin
      st0_r <= st0_nxt;
      st1_r <= st1_nxt;
      filt_r <= filt_nxt;
    end
  end

  assign o_filt = filt_r;
endmodule
`default_nettype wire

// file: hw/hdio_pkg.sv
/*
  constants shared by the header digital io port: pin counts, register
  groups and bank layout, reset values and the debounce sampling rate.
  assumes a 10 MHz system clock and a classic wishbone register bus.
*/
package hdio_pkg;
  // pin population
  localparam int HDIO_NPINS = 30;
  localparam int HDIO_NDED = 9;
  localparam int HDIO_NDISP = 11;
  localparam int HDIO_NSHR = 10;
  localparam int HDIO_NIRQ = 17;
  localparam int HDIO_REG_W = 8;
  localparam int HDIO_NBANK = 4;
  localparam int HDIO_VEC_W = HDIO_REG_W * HDIO_NBANK;
  // pin index layout: dedicated, then display group, then shared header
  localparam int HDIO_DED_FIRST = 0;
  localparam int HDIO_DISP_FIRST = HDIO_DED_FIRST + HDIO_NDED;
  localparam int HDIO_SHR_FIRST = HDIO_DISP_FIRST + HDIO_NDISP;
  localparam logic [31:0] HDIO_PIN_MASK = 32'h3FFFFFFF;
  localparam logic [31:0] HDIO_IRQ_MASK = 32'h0001FFFF;
  localparam logic [31:0] HDIO_LANE_MASK = 32'h000000FF;
  // bus address layout: byte address = group * 16 + bank * 4
  localparam int HDIO_ADR_W = 8;
  localparam int HDIO_GRP_HI = 7;
  localparam int HDIO_GRP_LO = 4;
  localparam int HDIO_BANK_HI = 3;
  localparam int HDIO_BANK_LO = 2;
  localparam logic [3:0] HDIO_GRP_DATA = 4'h0;
  localparam logic [3:0] HDIO_GRP_DIR = 4'h1;
  localparam logic [3:0] HDIO_GRP_IRQ_EN = 4'h2;
  localparam logic [3:0] HDIO_GRP_IRQ_EDGE = 4'h3;
  localparam logic [3:0] HDIO_GRP_IRQ_POL = 4'h4;
  localparam logic [3:0] HDIO_GRP_DEB_EN = 4'h5;
  localparam logic [3:0] HDIO_GRP_IRQ_STAT = 4'h6;
  localparam logic [3:0] HDIO_GRP_IRQ_CLR = 4'h7;
  // reset values
  localparam logic [31:0] HDIO_RST_VEC = 32'h00000000;
  localparam logic [31:0] HDIO_RD_ZERO = 32'h00000000;
  // debounce sampling clock
  localparam int HDIO_CLK_HZ = 10_000_000;
  localparam int HDIO_DEB_HZ = 128;
  localparam int HDIO_DEB_CYC = HDIO_CLK_HZ / HDIO_DEB_HZ;
endpackage

// file: hw/hdio_port.sv
/*
  header digital io port: 30 lines with per-pin direction and data,
  17 interrupt-capable lines with level/edge, polarity and debounce,
  reached through eight register groups of four byte-wide banks.
  registers are written on the edge that takes a request and answered
  with a one-cycle ack on the next; data group reads return the live pin levels.
  assumes a classic wishbone master on the 10 MHz clock, pin inputs
  already synchronous to that clock, and a board that resolves the
  driven and released level of each line outside this block.
*/
// Functional notes
// - thirty lines, each input or output
// - unused primary function lines become gpio
// - eleven display group, nine dedicated lines
// - registers hold eight bits, word aligned
// - upper 24 bits ignored, read zero
// - value and direction register per pin
// - direction one drives, zero is input
// - value writes touch only output pins
// - value reads return actual pin levels
// - seventeen lines may raise interrupts
// - high, low, rising or falling sensitivity
// - debounce enable per interrupt line
// - two-stage shift at 128 Hz
`timescale 1ns/1ps
`default_nettype none
module hdio_port
  import hdio_pkg::*;
#(
  parameter int DEB_TICK_CYCLES = hdio_pkg::HDIO_DEB_CYC
) (
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [hdio_pkg::HDIO_ADR_W-1:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  input wire logic [hdio_pkg::HDIO_NPINS-1:0] I_PIN_IN,
  input wire logic [hdio_pkg::HDIO_NPINS-1:0] I_PRIMARY_EN,
  output logic [hdio_pkg::HDIO_NPINS-1:0] O_PIN_OUT,
  output logic [hdio_pkg::HDIO_NPINS-1:0] O_PIN_OE,
  output logic O_IRQ
);
  import hdio_pkg::*;

  // tick counter sized for the divide; a short divide keeps simulation runs small
  localparam int TICK_W = $clog2(DEB_TICK_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(DEB_TICK_CYCLES - 1);

  // register state, held at 32 bits so banks index uniformly;
  // bits above each group's population are masked to zero on every write
  logic [31:0] out_r, out_nxt;
  logic [31:0] dir_r, dir_nxt;
  logic [31:0] ien_r, ien_nxt;
  logic [31:0] iedge_r, iedge_nxt;
  logic [31:0] ipol_r, ipol_nxt;
  logic [31:0] deb_r, deb_nxt;
  logic [31:0] stat_r, stat_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  // bus response, pin enable and divider state
  logic ack_r, ack_nxt;
  logic [HDIO_NPINS-1:0] oe_r, oe_nxt;
  logic [TICK_W-1:0] tick_cnt_r, tick_cnt_nxt;
  logic tick;
  // interrupt path: edge reference, chosen level and per-line edge flags
  logic [HDIO_NIRQ-1:0] lvl_prev_r, lvl_prev_nxt;
  logic [HDIO_NIRQ-1:0] filt, lvl, hit;
  logic [HDIO_NIRQ-1:0] rise, fall;
  // decode helpers
  logic [31:0] pins_vec, lane, wvec, clr_vec, hit_vec, rd_src;
  logic [3:0] grp;
  logic [1:0] bank;
  logic acc, wr;
  logic wr_data, wr_dir, wr_ien, wr_iedge, wr_ipol, wr_deb, wr_clr;

  // bus request decode; one access is taken per request, answered next cycle.
  // the ack register blocks a held strobe from being taken twice, so a master
  // must release the request at the edge on which it sees ack
  assign grp = I_WB_ADR[HDIO_GRP_HI:HDIO_GRP_LO];
  assign bank = I_WB_ADR[HDIO_BANK_HI:HDIO_BANK_LO];
  assign acc = I_WB_CYC & I_WB_STB & ~ack_r;
  assign wr = acc & I_WB_WE & I_WB_SEL[0];
  assign lane = HDIO_LANE_MASK << (HDIO_REG_W * bank);
  assign wvec = {HDIO_NBANK{I_WB_DAT[HDIO_REG_W-1:0]}} & lane;
  assign pins_vec = {{(HDIO_VEC_W - HDIO_NPINS){1'b0}}, I_PIN_IN};
  assign clr_vec = wr_clr ? wvec : HDIO_RST_VEC;
  assign hit_vec = {{(HDIO_VEC_W - HDIO_NIRQ){1'b0}}, hit};

  // one write strobe per register group keeps each next-value block small;
  // writes to unmapped groups match no strobe and are dropped.
  // a clear low-lane byte select suppresses the write, yet it is still acked
  assign wr_data = wr & (grp == HDIO_GRP_DATA);
  assign wr_dir = wr & (grp == HDIO_GRP_DIR);
  assign wr_ien = wr & (grp == HDIO_GRP_IRQ_EN);
  assign wr_iedge = wr & (grp == HDIO_GRP_IRQ_EDGE);
  assign wr_ipol = wr & (grp == HDIO_GRP_IRQ_POL);
  assign wr_deb = wr & (grp == HDIO_GRP_DEB_EN);
  assign wr_clr = wr & (grp == HDIO_GRP_IRQ_CLR);

  // debounce sampling enable, a one-cycle pulse at the filter rate;
  // the count restarts on the pulse, so the period is exactly DEB_TICK_CYCLES
  always_comb begin
    tick = (tick_cnt_r == TICK_LAST);
    tick_cnt_nxt = tick ? '0 : tick_cnt_r + 1'b1;
  end

  // only the interrupt-capable lines are filtered; the rest never raise events
  hdio_debounce #(
    .N(HDIO_NIRQ)
  ) u_deb (
    .i_clk(I_MCLK),
    .i_rst(I_RST),
    .i_tick(tick),
    .i_din(I_PIN_IN[HDIO_NIRQ-1:0]),
    .o_filt(filt)
  );

  // per interrupt line: pick the raw or filtered level, then classify it.
  // the capable lines are the dedicated group then the first eight display lines;
  // a disabled line never sets status, so enabling cannot replay an old event.
  // a line in level mode sets its status again every cycle while it is active
  genvar gi;
  generate
    for (gi = 0; gi < HDIO_NIRQ; gi++) begin : g_irq
      assign lvl[gi] = deb_r[gi] ? filt[gi] : I_PIN_IN[gi];
      assign rise[gi] = lvl[gi] & ~lvl_prev_r[gi];
      assign fall[gi] = ~lvl[gi] & lvl_prev_r[gi];
      always_comb begin
        if (iedge_r[gi]) begin
          hit[gi] = ien_r[gi] & (ipol_r[gi] ? rise[gi] : fall[gi]);
        end else begin
          hit[gi] = ien_r[gi] & (lvl[gi] == ipol_r[gi]);
        end
      end
    end
  endgenerate

  // edge reference: this cycle's level is compared against on the next cycle
  always_comb begin
    lvl_prev_nxt = lvl;
  end

  // pin registers; a data write is masked by the direction held before it,
  // so turning a line into an output and driving it takes two writes
  always_comb begin
    out_nxt = out_r;
    dir_nxt = dir_r;
    if (wr_data) begin
      out_nxt = (out_r & ~(lane & dir_r)) | (wvec & dir_r);
    end
    if (wr_dir) begin
      dir_nxt = ((dir_r & ~lane) | wvec) & HDIO_PIN_MASK;
    end
  end

  // interrupt configuration; only the low byte lane of the word carries data.
  // edge selects edge mode, polarity selects high level or rising edge
  always_comb begin
    ien_nxt = ien_r;
    iedge_nxt = iedge_r;
    ipol_nxt = ipol_r;
    deb_nxt = deb_r;
    if (wr_ien) begin
      ien_nxt = ((ien_r & ~lane) | wvec) & HDIO_IRQ_MASK;
    end
    if (wr_iedge) begin
      iedge_nxt = ((iedge_r & ~lane) | wvec) & HDIO_IRQ_MASK;
    end
    if (wr_ipol) begin
      ipol_nxt = ((ipol_r & ~lane) | wvec) & HDIO_IRQ_MASK;
    end
    if (wr_deb) begin
      deb_nxt = ((deb_r & ~lane) | wvec) & HDIO_IRQ_MASK;
    end
  end

  // sticky status: a new hit in the clearing cycle survives the clear.
  // the clear register is write-only: a one clears, a zero leaves the bit alone
  always_comb begin
    stat_nxt = ((stat_r & ~clr_vec) | hit_vec) & HDIO_IRQ_MASK;
  end

  // read source; unmapped offsets and the write-only clear read as zero.
  // the data group reads the live pins, not the output latch
  always_comb begin
    rd_src = HDIO_RD_ZERO;
    if (grp == HDIO_GRP_DATA) begin
      rd_src = pins_vec;
    end else if (grp == HDIO_GRP_DIR) begin
      rd_src = dir_r;
    end else if (grp == HDIO_GRP_IRQ_EN) begin
      rd_src = ien_r;
    end else if (grp == HDIO_GRP_IRQ_EDGE) begin
      rd_src = iedge_r;
    end else if (grp == HDIO_GRP_IRQ_POL) begin
      rd_src = ipol_r;
    end else if (grp == HDIO_GRP_DEB_EN) begin
      rd_src = deb_r;
    end else if (grp == HDIO_GRP_IRQ_STAT) begin
      rd_src = stat_r;
    end
  end

  // bus response; read data are registered, so they stand with the ack and
  // hold until the next access
  always_comb begin
    rdat_nxt = rdat_r;
    if (acc) begin
      rdat_nxt = {24'h000000, rd_src[HDIO_REG_W * bank +: HDIO_REG_W]};
    end
    ack_nxt = acc;
  end

  // pin enables follow direction unless the header's primary function owns the pin;
  // the enable lags a direction write by one cycle
  always_comb begin
    oe_nxt = dir_r[HDIO_NPINS-1:0] & ~I_PRIMARY_EN;
  end

  // pin group registers; all lines come out of reset as inputs.
  // the output latch keeps its value while a line is an input
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      out_r <= HDIO_RST_VEC;
      dir_r <= HDIO_RST_VEC;
      oe_r <= '0;
    end else begin
      out_r <= out_nxt;
      dir_r <= dir_nxt;
      oe_r <= oe_nxt;
    end
  end

  // interrupt configuration registers; every line starts disabled
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      ien_r <= HDIO_RST_VEC;
      iedge_r <= HDIO_RST_VEC;
      ipol_r <= HDIO_RST_VEC;
      deb_r <= HDIO_RST_VEC;
    end else begin
      ien_r <= ien_nxt;
      iedge_r <= iedge_nxt;
      ipol_r <= ipol_nxt;
      deb_r <= deb_nxt;
    end
  end

  // interrupt status register; bits survive a disable so software can still
  // see what happened before the line was masked
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      stat_r <= HDIO_RST_VEC;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // bus response registers; ack drops the cycle after it was given
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      rdat_r <= HDIO_RD_ZERO;
      ack_r <= 1'b0;
    end else begin
      rdat_r <= rdat_nxt;
      ack_r <= ack_nxt;
    end
  end

  // debounce divider; free running, so the first sample after an enable
  // comes anywhere within one tick period
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
    end
  end

  // edge reference; interrupts start disabled and need an enable write, so the
  // cleared reference never turns into a false edge
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      lvl_prev_r <= '0;
    end else begin
      lvl_prev_r <= lvl_prev_nxt;
    end
  end

  // outputs: thirty lines spanning the three header groups.
  // the interrupt is a level: high while an enabled status bit is set
  assign O_PIN_OUT = out_r[HDIO_NPINS-1:0];
  assign O_PIN_OE = oe_r;
  assign O_WB_DAT = rdat_r;
  assign O_WB_ACK = ack_r;
  assign O_IRQ = |(stat_r & ien_r);
endmodule
`default_nettype wire

// file: verif/hdio_checker.sv
/* checker for the header io port: bus, pin and reset relations.
   assumes it is bound to every hdio_port instance. */
`timescale 1ns/1ps
`default_nettype none
module hdio_chk (
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  input wire logic [31:0] O_WB_DAT,
  input wire logic O_WB_ACK,
  input wire logic [29:0] I_PIN_IN,
  input wire logic [29:0] I_PRIMARY_EN,
  input wire logic [29:0] O_PIN_OUT,
  input wire logic [29:0] O_PIN_OE,
  input wire logic O_IRQ
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  logic tk;
  // a request is taken only while no ack stands, else a held strobe counts twice
  assign tk = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
  AST_ACK_ONE: assert property (tk |=> O_WB_ACK)
    else $error("ack late");
  AST_ACK_PULSE: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack held");
  AST_RD_UPPER: assert property (O_WB_ACK |-> O_WB_DAT[31:8] == 24'h000000)
    else $error("upper bits set");
  AST_RD_PIN: assert property (tk && !I_WB_WE && I_WB_ADR == 8'h00
    |=> O_WB_DAT[7:0] == $past(I_PIN_IN[7:0])) else $error("pin read");
  AST_OUT_HOLD: assert property (!(tk && I_WB_WE) |=> $stable(O_PIN_OUT))
    else $error("out moved");
  AST_OE_PRIM: assert property ((O_PIN_OE & $past(I_PRIMARY_EN)) == 30'h0)
    else $error("primary driven");
  AST_OE_DIR: assert property (tk && I_WB_WE && I_WB_SEL[0] && I_WB_ADR == 8'h10
    && I_PRIMARY_EN == 30'h0 |-> ##2 O_PIN_OE[7:0] == $past(I_WB_DAT[7:0], 2))
    else $error("oe wrong");
  AST_RST_IDLE: assert property ($past(I_RST) |-> !O_IRQ && O_PIN_OE == 30'h0)
    else $error("not idle");
endmodule
bind hdio_port hdio_chk chk_u (.*);
`default_nettype wire

// file: verif/hdio_pin_model.sv
/* pin partner: board side of the header lines.
   assumes the bench sets the level of undriven lines through i_ext. */
`timescale 1ns/1ps
`default_nettype none
module hdio_pin_model (
  input wire logic [29:0] i_out,
  input wire logic [29:0] i_oe,
  input wire logic [29:0] i_ext,
  output logic [29:0] o_lvl
);
  // a driven line shows the port's level, a released one the board's
  assign o_lvl = (i_oe & i_out) | (~i_oe & i_ext);
endmodule
`default_nettype wire

// file: verif/tb_top.sv
/* bench for the header io port: registers, pins, interrupts, debounce.
   assumes a short debounce tick and the pin partner model. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rst, cyc, stb, we, ack, irq;
  logic [7:0] adr, o;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [29:0] pin, prim, pout, poe, ext;
  int n_errors, check_count, p;
  hdio_port #(.DEB_TICK_CYCLES(4)) dut_u (.I_MCLK(clk), .I_RST(rst), .I_WB_CYC(cyc),
    .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
    .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_PIN_IN(pin), .I_PRIMARY_EN(prim),
    .O_PIN_OUT(pout), .O_PIN_OE(poe), .O_IRQ(irq));
  hdio_pin_model pm_u (.i_out(pout), .i_oe(poe), .i_ext(ext), .o_lvl(pin));
  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one classic cycle; the wait is bounded so a dead slave ends the run
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      n_errors++;
      conclude();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic t_reg();
    rd(8'h10, 32'h0);
    rd(8'h20, 32'h0);
    wb(1'b1, 8'h10, 32'hFFFFFF5A);
    rd(8'h10, 32'h5A);
    wb(1'b1, 8'h1C, 32'hFF);
    rd(8'h1C, 32'h3F);
    wb(1'b1, 8'h90, 32'hFF);
    rd(8'h90, 32'h0);
    $display("registers done");
  endtask
  task automatic t_pins();
    ext <= 30'h0F;
    wb(1'b1, 8'h00, 32'hFF);
    wt(2);
    chk(32'(poe[7:0]), 32'h5A);
    chk(32'(pout[7:0]), 32'h5A);
    rd(8'h00, 32'h5F);
    prim <= 30'h2;
    wt(3);
    chk(32'(poe[7:0]), 32'h58);
    prim <= 30'h0;
    $display("pins done");
  endtask
  // every mode on a dedicated and a display line
  task automatic t_irq();
    for (int j = 0; j < 8; j++) begin
      p = j[2] ? 16 : 0;
      o = j[2] ? 8'h08 : 8'h00;
      ext[p] <= ~j[0];
      wb(1'b1, 8'h30 | o, 32'(j[1]));
      wb(1'b1, 8'h40 | o, 32'(j[0]));
      wb(1'b1, 8'h70 | o, 32'h1);
      wb(1'b1, 8'h20 | o, 32'h1);
      wt(1);
      chk(32'(irq), 32'h0);
      ext[p] <= j[0];
      wt(3);
      chk(32'(irq), 32'h1);
      ext[p] <= ~j[0];
      wt(2);
      wb(1'b1, 8'h70 | o, 32'h1);
      wt(1);
      chk(32'(irq), 32'h0);
      wb(1'b1, 8'h20 | o, 32'h0);
    end
    $display("interrupts done");
  endtask
  // a one-cycle glitch must not pass the filter, a steady level must
  task automatic t_deb();
    ext[0] <= 1'b0;
    wb(1'b1, 8'h30, 32'h0);
    wb(1'b1, 8'h40, 32'h1);
    wb(1'b1, 8'h50, 32'h1);
    wb(1'b1, 8'h70, 32'h1);
    wb(1'b1, 8'h20, 32'h1);
    @(posedge clk);
    ext[0] <= 1'b1;
    @(posedge clk);
    ext[0] <= 1'b0;
    wt(16);
    chk(32'(irq), 32'h0);
    ext[0] <= 1'b1;
    wt(16);
    chk(32'(irq), 32'h1);
    wb(1'b1, 8'h20, 32'h0);
    wt(1);
    chk(32'(irq), 32'h0);
    rd(8'h60, 32'h1);
    $display("debounce done");
  endtask
  // reset, then the scenarios in turn
  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h0;
    prim = 30'h0;
    ext = 30'h0;
    n_errors = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reg();
    t_pins();
    t_irq();
    t_deb();
    conclude();
  end
endmodule
`default_nettype wire
